// >>> core/mbs_defs.svh
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH
// Summary of operation
// - slave only: answers one response per accepted request, never initiates
// - stay silent when the address byte differs from the configured unit
// - unit number 1 to 15, zero not allowed, default unit is one
// - writes accepted only in serial remote control mode, reads always
// - write response sent only after the write has fully finished
// - setpoint goes to nonvolatile store only when it differs from the current setpoint
// - after restart the setpoint resumes from the nonvolatile store
// - frame body bytes travel as two ASCII hex characters, high first
// - every frame starts with a colon
// - every frame ends with carriage return then line feed
// - no response without leading colon and trailing CR LF
// - a received colon discards buffered characters, but restarts assembly only in the HUNT, BODY and LFW states, not in EXEC, NVW or TX
// - read response byte count is twice registers, values high byte first
// - register internal_sensor_temperature returns discharge temperature in 0.01 degree units
// - entering remote mode halts control and locks panel setpoint changes
// - supported functions: 03h, 06h, 10h and 17h
// - LRC is two's complement of eight bit sum of body bytes
// - frames whose LRC does not check are dropped silently

`define MBS_CH_COLON    8'h3a
`define MBS_CH_CR       8'h0d
`define MBS_CH_LF       8'h0a
`define MBS_UNIT_ZERO   4'h0
`define MBS_UNIT_DEF    4'h1
`define MBS_FN_READ     8'h03
`define MBS_FN_WRITE1   8'h06
`define MBS_FN_WRITEN   8'h10
`define MBS_FN_RDWR     8'h17
`define MBS_REG_TEMP    16'h0040
`define MBS_REG_SETPT   16'h000b
`define MBS_SETPT_RST   16'h0000
`define MBS_HDR_LEN     8'h03
`define MBS_ECHO_LEN    8'h06
`define MBS_LEN_FIXED   8'h07
`define MBS_LEN_WRN     8'h08
`define MBS_LEN_RDWR    8'h0c
`define MBS_OFF_ADDR    2
`define MBS_OFF_QTY     4
`define MBS_OFF_BC      6
`define MBS_OFF_WADDR   6
`define MBS_OFF_WQTY    8
`define MBS_OFF_BC17    10
`define MBS_VOFF_W1     5'h04
`define MBS_VOFF_WN     5'h07
`define MBS_VOFF_RW     5'h0b
`define MBS_STEP_COLON  2'h0
`define MBS_STEP_BODY   2'h1
`define MBS_STEP_CR     2'h2
`define MBS_STEP_LF     2'h3
`endif

// >>> core/mbs_pkg.sv
package mbs_pkg;
  typedef enum logic [2:0] {
    MBS_HUNT  = 3'h0,
    MBS_BODY  = 3'h1,
    MBS_LFW   = 3'h3,
    MBS_EXEC  = 3'h2,
    MBS_NVW   = 3'h6,
    MBS_TX    = 3'h7
  } mbs_state_t;
endpackage

// >>> core/mbs_hex_codec.sv
`timescale 1ns/1ps
module mbs_hex_codec (
  input  wire logic [7:0] asciiIn,
  output logic      [3:0] nibbleOut,
  output logic            isHex,
  input  wire logic [3:0] nibbleIn,
  output logic      [7:0] asciiOut
);
  always_comb begin
    isHex     = 1'b1;
    nibbleOut = 4'h0;
    if (asciiIn >= 8'h30 && asciiIn <= 8'h39) begin
      nibbleOut = asciiIn[3:0];
    end else if ((asciiIn >= 8'h41 && asciiIn <= 8'h46) ||
                 (asciiIn >= 8'h61 && asciiIn <= 8'h66)) begin
      nibbleOut = asciiIn[3:0] + 4'h9;
    end else begin
      isHex = 1'b0;
    end
  end

  // upper case on the way out, either case accepted on the way in
  always_comb begin
    if (nibbleIn < 4'ha) begin
      asciiOut = {4'h3, nibbleIn};
    end else begin
      asciiOut = {4'h4, nibbleIn - 4'h9};
    end
  end
endmodule

// >>> core/mbs_ascii_slave.sv
`timescale 1ns/1ps
`include "mbs_defs.svh"
module mbs_ascii_slave #(
  parameter int DEPTH    = 32,
  parameter int MAX_READ = 8
) (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic [7:0]         rxData,
  input  wire logic               rxValid,
  output logic      [7:0]         txData,
  output logic                    txValid,
  input  wire logic               txReady,
  input  wire logic [3:0]         unitNumber,
  input  wire logic               serialRemoteMode,
  input  wire logic [15:0]        sensorTemp,
  input  wire logic               panelSetValid,
  input  wire logic [15:0]        panelSetData,
  input  wire logic [15:0]        nvStoredSetpoint,
  output logic                    nvWriteStrobe,
  output logic      [15:0]        nvWriteData,
  input  wire logic               nvDone,
  output logic      [15:0]        setpoint,
  output logic                    controlHalt,
  output logic                    panelLock,
  output mbs_pkg::mbs_state_t     frontState
);
  import mbs_pkg::*;
  localparam int IW = $clog2(DEPTH);

  mbs_state_t  state_r;
  logic [7:0]  bufMem [DEPTH];
  logic [7:0]  rxCount_r;
  logic        rxHalf_r;
  logic [3:0]  rxHi_r;
  logic [7:0]  rxSum_r;
  logic [15:0] setpoint_r;
  logic        loadPending_r;
  logic        remotePrev_r;
  logic [1:0]  txStep_r;
  logic [7:0]  txIdx_r;
  logic        txLo_r;
  logic [7:0]  txLrc_r;
  logic [7:0]  txData_r;
  logic        txValid_r;
  logic        nvStrobe_r;

  logic [3:0]  rxNib;
  logic        rxIsHex;
  logic [3:0]  txNib;
  logic [7:0]  txAscii;

  mbs_hex_codec codec (
    .asciiIn   (rxData),
    .nibbleOut (rxNib),
    .isHex     (rxIsHex),
    .nibbleIn  (txNib),
    .asciiOut  (txAscii)
  );

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  logic [3:0]  effUnit;
  logic [7:0]  fn;
  logic [15:0] a1, q1, wAddr, wQty, diff, newVal;
  logic [IW-1:0] vOff, vIdx;
  logic        unitOk, lenOk, isWrite, writeHit, frameOk, rxColon;
  logic [7:0]  respLen;
  logic        isEcho;

  // unit zero cannot be configured, fall back to the default unit
  assign effUnit = (unitNumber == `MBS_UNIT_ZERO) ? `MBS_UNIT_DEF : unitNumber;
  assign fn      = bufMem[1];
  assign a1      = {bufMem[`MBS_OFF_ADDR], bufMem[`MBS_OFF_ADDR+1]};
  assign q1      = {bufMem[`MBS_OFF_QTY], bufMem[`MBS_OFF_QTY+1]};
  assign unitOk  = bufMem[0] == {4'h0, effUnit};
  assign rxColon = rxValid && rxData == `MBS_CH_COLON;

  always_comb begin
    lenOk   = 1'b0;
    isWrite = 1'b1;
    wAddr   = a1;
    wQty    = 16'h0001;
    vOff    = `MBS_VOFF_W1;
    case (fn)
      `MBS_FN_READ: begin
        isWrite = 1'b0;
        wQty    = 16'h0000;
        lenOk   = rxCount_r == `MBS_LEN_FIXED && q1 != 16'h0 && q1 <= 16'(MAX_READ);
      end
      `MBS_FN_WRITE1: begin
        lenOk = rxCount_r == `MBS_LEN_FIXED;
      end
      `MBS_FN_WRITEN: begin
        wQty  = q1;
        vOff  = `MBS_VOFF_WN;
        lenOk = rxCount_r == `MBS_LEN_WRN + bufMem[`MBS_OFF_BC] &&
                {8'h00, bufMem[`MBS_OFF_BC]} == {q1[14:0], 1'b0} && q1 != 16'h0;
      end
      `MBS_FN_RDWR: begin
        wAddr = {bufMem[`MBS_OFF_WADDR], bufMem[`MBS_OFF_WADDR+1]};
        wQty  = {bufMem[`MBS_OFF_WQTY], bufMem[`MBS_OFF_WQTY+1]};
        vOff  = `MBS_VOFF_RW;
        lenOk = rxCount_r == `MBS_LEN_RDWR + bufMem[`MBS_OFF_BC17] &&
                {8'h00, bufMem[`MBS_OFF_BC17]} == {wQty[14:0], 1'b0} &&
                q1 != 16'h0 && q1 <= 16'(MAX_READ) && wQty != 16'h0;
      end
      default: begin
        isWrite = 1'b0;
        wQty    = 16'h0000;
      end
    endcase
  end

  assign diff     = `MBS_REG_SETPT - wAddr;
  assign writeHit = isWrite && diff < wQty;
  assign vIdx     = IW'(vOff + {diff[IW-2:0], 1'b0});
  assign newVal   = {bufMem[vIdx], bufMem[IW'(vIdx + 1'b1)]};
  // bad LRC, wrong unit, bad length or a locked write all end in silence
  assign frameOk  = rxSum_r == 8'h00 && unitOk && lenOk &&
                    (!isWrite || serialRemoteMode);
  assign isEcho   = fn == `MBS_FN_WRITE1 || fn == `MBS_FN_WRITEN;
  assign respLen  = isEcho ? `MBS_ECHO_LEN : `MBS_HDR_LEN + {q1[6:0], 1'b0};

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  logic txLoad;
  assign txLoad = state_r == MBS_TX && (!txValid_r || txReady);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= MBS_HUNT;
    end else begin
      case (state_r)
        MBS_HUNT: if (rxColon) state_r <= MBS_BODY;
        MBS_BODY: begin
          if (rxValid && !rxColon) begin
            if (rxData == `MBS_CH_CR) begin
              state_r <= rxHalf_r ? MBS_HUNT : MBS_LFW;
            end else if (!rxIsHex || (rxHalf_r && rxCount_r == 8'(DEPTH))) begin
              state_r <= MBS_HUNT;
            end
          end
        end
        MBS_LFW: begin
          if (rxValid) begin
            if (rxColon) state_r <= MBS_BODY;
            else if (rxData == `MBS_CH_LF) state_r <= MBS_EXEC;
            else state_r <= MBS_HUNT;
          end
        end
        MBS_EXEC: begin
          if (!frameOk) state_r <= MBS_HUNT;
          else if (writeHit && newVal != setpoint_r) state_r <= MBS_NVW;
          else state_r <= MBS_TX;
        end
        MBS_NVW: if (nvDone) state_r <= MBS_TX;
        MBS_TX: if (txLoad && txStep_r == `MBS_STEP_LF) state_r <= MBS_HUNT;
        default: state_r <= MBS_HUNT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive assembly
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rxColon) begin
      rxCount_r <= 8'h00;
      rxSum_r   <= 8'h00;
      rxHalf_r  <= 1'b0;
    end else if (state_r == MBS_BODY && rxValid && rxIsHex) begin
      rxHalf_r <= !rxHalf_r;
      if (!rxHalf_r) begin
        rxHi_r <= rxNib;
      end else if (rxCount_r != 8'(DEPTH)) begin
        bufMem[rxCount_r[IW-1:0]] <= {rxHi_r, rxNib};
        rxCount_r <= rxCount_r + 8'h01;
        rxSum_r   <= rxSum_r + {rxHi_r, rxNib};
      end
    end
  end

  // ----------------------------------------------------------------
  // setpoint and nonvolatile store
  // ----------------------------------------------------------------
  logic nvCommit;
  assign nvCommit = state_r == MBS_EXEC && frameOk && writeHit && newVal != setpoint_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      setpoint_r    <= `MBS_SETPT_RST;
      loadPending_r <= 1'b1;
      nvStrobe_r    <= 1'b0;
      nvWriteData   <= `MBS_SETPT_RST;
    end else begin
      nvStrobe_r <= nvCommit;
      if (loadPending_r) begin
        setpoint_r    <= nvStoredSetpoint;
        loadPending_r <= 1'b0;
      end else if (nvCommit) begin
        setpoint_r  <= newVal;
        nvWriteData <= newVal;
      end else if (panelSetValid && !serialRemoteMode) begin
        setpoint_r <= panelSetData;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      remotePrev_r <= 1'b0;
      controlHalt  <= 1'b0;
    end else begin
      remotePrev_r <= serialRemoteMode;
      controlHalt  <= serialRemoteMode && !remotePrev_r;
    end
  end

  // ----------------------------------------------------------------
  // response transmit
  // ----------------------------------------------------------------
  function automatic logic [15:0] regRead(input logic [15:0] addr);
    if (addr == `MBS_REG_TEMP) return sensorTemp;
    if (addr == `MBS_REG_SETPT) return setpoint_r;
    return 16'h0000;
  endfunction

  logic [7:0]  sub;
  logic [15:0] rdWord;
  logic [7:0]  curByte;
  logic [7:0]  nextChar;
  assign sub    = txIdx_r - `MBS_HDR_LEN;
  assign rdWord = regRead(a1 + {9'h000, sub[7:1]});

  always_comb begin
    if (txIdx_r == respLen) curByte = ~txLrc_r + 8'h01;
    else if (isEcho || txIdx_r < 8'h02) curByte = bufMem[txIdx_r[IW-1:0]];
    else if (txIdx_r == 8'h02) curByte = {q1[6:0], 1'b0};
    else curByte = sub[0] ? rdWord[7:0] : rdWord[15:8];
  end

  assign txNib = txLo_r ? curByte[3:0] : curByte[7:4];

  always_comb begin
    case (txStep_r)
      `MBS_STEP_COLON: nextChar = `MBS_CH_COLON;
      `MBS_STEP_BODY:  nextChar = txAscii;
      `MBS_STEP_CR:    nextChar = `MBS_CH_CR;
      default:         nextChar = `MBS_CH_LF;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      txStep_r  <= `MBS_STEP_COLON;
      txIdx_r   <= 8'h00;
      txLo_r    <= 1'b0;
      txLrc_r   <= 8'h00;
      txData_r  <= 8'h00;
      txValid_r <= 1'b0;
    end else begin
      if (txValid_r && txReady) txValid_r <= 1'b0;
      if (state_r != MBS_TX) begin
        txStep_r <= `MBS_STEP_COLON;
        txIdx_r  <= 8'h00;
        txLo_r   <= 1'b0;
        txLrc_r  <= 8'h00;
      end else if (txLoad) begin
        txData_r  <= nextChar;
        txValid_r <= 1'b1;
        if (txStep_r == `MBS_STEP_BODY) begin
          txLo_r <= !txLo_r;
          if (txLo_r) begin
            txLrc_r <= txLrc_r + curByte;
            if (txIdx_r == respLen) txStep_r <= `MBS_STEP_CR;
            else txIdx_r <= txIdx_r + 8'h01;
          end
        end else begin
          txStep_r <= txStep_r + 2'h1;
        end
      end
    end
  end

  assign txData        = txData_r;
  assign txValid       = txValid_r;
  assign nvWriteStrobe = nvStrobe_r;
  assign setpoint      = setpoint_r;
  assign panelLock     = serialRemoteMode;
  assign frontState    = state_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  slave_only_a: assert property ($rose(txValid) |-> $past(state_r) == MBS_TX)
    else $error("transmit started outside a response");
  unit_silent_a: assert property (state_r == MBS_EXEC && !unitOk |=> state_r == MBS_HUNT)
    else $error("foreign unit not ignored");
  write_lock_a: assert property (state_r == MBS_EXEC && isWrite && !serialRemoteMode
                                 |=> state_r == MBS_HUNT)
    else $error("write taken outside remote mode");
  nv_hold_a: assert property (state_r == MBS_NVW && !nvDone |=> state_r == MBS_NVW)
    else $error("response before write done");
  nv_same_a: assert property (state_r == MBS_EXEC && writeHit && newVal == setpoint_r
                              |=> !nvWriteStrobe)
    else $error("redundant nonvolatile write");
  tx_colon_a: assert property (txLoad && txStep_r == `MBS_STEP_COLON
                               |=> txData == `MBS_CH_COLON && txValid)
    else $error("frame not opened by colon");
  tx_end_a: assert property (txLoad && txStep_r == `MBS_STEP_CR
                             |=> txData == `MBS_CH_CR ##[1:4] txData == `MBS_CH_LF)
    else $error("frame not closed by CR LF");
  colon_clear_a: assert property (rxColon |=> rxCount_r == 8'h00 && !rxHalf_r)
    else $error("colon did not restart assembly");
  lrc_drop_a: assert property (state_r == MBS_EXEC && rxSum_r != 8'h00
                               |=> state_r == MBS_HUNT)
    else $error("bad LRC frame not dropped");
  odd_drop_a: assert property (state_r == MBS_BODY && rxValid && rxData == `MBS_CH_CR &&
                               rxHalf_r |=> state_r == MBS_HUNT)
    else $error("odd hex count not dropped");

  read_resp_c: cover property (state_r == MBS_EXEC && frameOk && fn == `MBS_FN_READ);
  nv_write_c: cover property (state_r == MBS_NVW ##[1:20] state_r == MBS_TX);
  restart_c: cover property (state_r == MBS_LFW && rxColon);
endmodule

// >>> test/mbs_tb_types.svh
`ifndef MBS_TB_TYPES_SVH
`define MBS_TB_TYPES_SVH
typedef logic [7:0] mbs_bytes_t[$];
`endif

// >>> test/mbs_master_model.sv
`timescale 1ns/1ps
`include "mbs_tb_types.svh"
module mbs_master_model #(
  parameter int GAP_CYCLES = 20
) (
  input  wire logic       core_clk,
  input  wire logic       slow,
  output logic      [7:0] rxData,
  output logic            rxValid,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady
);
  mbs_bytes_t got;

  initial begin
    rxData  = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b1;
  end

  // ----------------------------------------
  // framing helpers
  // ----------------------------------------
  function automatic logic [7:0] hexOf(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction

  function automatic void toChars(input mbs_bytes_t body, output mbs_bytes_t chars);
    logic [7:0] sum;
    sum = 8'h00;
    chars = {8'h3a};
    foreach (body[i]) sum += body[i];
    body.push_back(8'h00 - sum);
    foreach (body[i]) begin
      chars.push_back(hexOf(body[i][7:4]));
      chars.push_back(hexOf(body[i][3:0]));
    end
    chars.push_back(8'h0d);
    chars.push_back(8'h0a);
  endfunction

  // ----------------------------------------
  // request side
  // ----------------------------------------
  task automatic sendChars(input mbs_bytes_t chars);
    foreach (chars[i]) begin
      @(negedge core_clk);
      rxData  <= chars[i];
      rxValid <= 1'b1;
    end
    @(negedge core_clk);
    rxValid <= 1'b0;
    // released line must not keep showing the last char
    rxData  <= ~rxData;
  endtask

  // shortened from the real inter-request pause to keep the run short
  task automatic waitGap();
    repeat (GAP_CYCLES) @(negedge core_clk);
  endtask

  // ----------------------------------------
  // response side, optionally stalling
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (txValid && txReady) begin
      got.push_back(txData);
    end
  end

  always @(negedge core_clk) begin
    txReady <= slow ? ~txReady : 1'b1;
  end
endmodule

// >>> test/tb_mbs_ascii_slave.sv
`timescale 1ns/1ps
`include "mbs_tb_types.svh"
module tb_mbs_ascii_slave;
  import mbs_pkg::*;
  localparam int NV_DELAY = 40;
  logic        core_clk, reset, slow, rxValid, txValid, txReady, serialRemoteMode;
  logic        panelSetValid, nvWriteStrobe, nvDone, controlHalt, panelLock, early;
  logic [7:0]  rxData, txData;
  logic [3:0]  unitNumber;
  logic [15:0] sensorTemp, panelSetData, nvStoredSetpoint, nvWriteData, setpoint, lastNv;
  mbs_state_t  frontState;
  int          miscompares, samplesChecked, strobes, nvCnt, halts;

  mbs_ascii_slave uut (
    .core_clk(core_clk), .reset(reset), .rxData(rxData), .rxValid(rxValid),
    .txData(txData), .txValid(txValid), .txReady(txReady), .unitNumber(unitNumber),
    .serialRemoteMode(serialRemoteMode), .sensorTemp(sensorTemp),
    .panelSetValid(panelSetValid), .panelSetData(panelSetData),
    .nvStoredSetpoint(nvStoredSetpoint), .nvWriteStrobe(nvWriteStrobe),
    .nvWriteData(nvWriteData), .nvDone(nvDone), .setpoint(setpoint),
    .controlHalt(controlHalt), .panelLock(panelLock), .frontState(frontState)
  );

  mbs_master_model master (
    .core_clk(core_clk), .slow(slow), .rxData(rxData), .rxValid(rxValid),
    .txData(txData), .txValid(txValid), .txReady(txReady)
  );

  // ----------------------------------------
  // nonvolatile store stand-in
  // ----------------------------------------
  always @(negedge core_clk) begin
    if (nvWriteStrobe) begin
      nvCnt   <= NV_DELAY;
      strobes <= strobes + 1;
      lastNv  <= nvWriteData;
    end else if (nvCnt != 0) begin
      nvCnt <= nvCnt - 1;
    end
    nvDone <= (nvCnt == 1);
    // any answer while the store is busy is too early
    if (txValid && nvCnt != 0) early <= 1'b1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic printVerdict();
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // mode 1 bad lrc, 2 non-hex char, 3 no line feed
  task automatic send(input mbs_bytes_t body, input int mode);
    mbs_bytes_t c;
    master.toChars(body, c);
    if (mode == 1) c[c.size()-4] = (c[c.size()-4] == 8'h30) ? 8'h31 : 8'h30;
    if (mode == 2) c[3] = 8'h47;
    if (mode == 3) void'(c.pop_back());
    master.sendChars(c);
  endtask

  task automatic expectResp(input mbs_bytes_t body);
    mbs_bytes_t exp;
    int n;
    master.toChars(body, exp);
    n = 0;
    // bounded wait stands in for the master's give-up-and-resend limit
    while (master.got.size() < exp.size() && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: response timed out", $time);
      printVerdict();
    end
    chkVal(16'(master.got.size()), 16'(exp.size()), "response length");
    foreach (exp[i]) begin
      if (i < master.got.size()) chkVal({8'h00, master.got[i]}, {8'h00, exp[i]}, "char");
    end
    master.got.delete();
    master.waitGap();
  endtask

  task automatic expectNone();
    repeat (300) @(negedge core_clk);
    chkVal(16'(master.got.size()), 16'h0000, "unexpected response");
    master.got.delete();
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    {miscompares, samplesChecked, strobes, nvCnt, halts} = '0;
    {reset, early, slow} = 3'b101;
    {serialRemoteMode, panelSetValid, nvDone} = 3'b000;
    unitNumber = 4'h1;
    sensorTemp = 16'h094d;
    panelSetData = 16'h0190;
    nvStoredSetpoint = 16'h00c8;
    lastNv = 16'h0000;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    chkVal(setpoint, 16'h00c8, "setpoint after restart");
    send({8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, 0);
    expectResp({8'h01, 8'h03, 8'h02, 8'h09, 8'h4d});
    slow = 1'b0;
    send({8'h02, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, 0);
    expectNone();
    send({8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, 1);
    expectNone();
    send({8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, 2);
    expectNone();
    send({8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, 3);
    expectNone();
    chkVal({13'h0000, frontState}, 16'h0003, "waiting for line feed");
    master.sendChars({8'h3a, 8'h30, 8'h31, 8'h30});
    send({8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, 0);
    expectResp({8'h01, 8'h03, 8'h02, 8'h09, 8'h4d});
    send({8'h01, 8'h06, 8'h00, 8'h0b, 8'h12, 8'h34}, 0);
    expectNone();
    chkVal(setpoint, 16'h00c8, "setpoint after refused write");
    @(negedge core_clk);
    panelSetValid = 1'b1;
    @(negedge core_clk);
    panelSetValid = 1'b0;
    chkVal(setpoint, 16'h0190, "panel change while unlocked");
    panelSetData = 16'h0200;
    serialRemoteMode = 1'b1;
    repeat (4) begin
      @(posedge core_clk);
      #1 halts += int'(controlHalt);
    end
    chkVal(16'(halts), 16'h0001, "halt pulses");
    chkVal({15'h0000, panelLock}, 16'h0001, "panel lock");
    @(negedge core_clk);
    panelSetValid = 1'b1;
    @(negedge core_clk);
    panelSetValid = 1'b0;
    chkVal(setpoint, 16'h0190, "panel change while locked");
    send({8'h01, 8'h06, 8'h00, 8'h0b, 8'h12, 8'h34}, 0);
    expectResp({8'h01, 8'h06, 8'h00, 8'h0b, 8'h12, 8'h34});
    chkVal({15'h0000, early}, 16'h0000, "answer before store done");
    chkVal(16'(strobes), 16'h0001, "store writes");
    chkVal(lastNv, 16'h1234, "stored value");
    send({8'h01, 8'h06, 8'h00, 8'h0b, 8'h12, 8'h34}, 0);
    expectResp({8'h01, 8'h06, 8'h00, 8'h0b, 8'h12, 8'h34});
    chkVal(16'(strobes), 16'h0001, "store writes, same value");
    send({8'h01, 8'h03, 8'h00, 8'h0b, 8'h00, 8'h01}, 0);
    expectResp({8'h01, 8'h03, 8'h02, 8'h12, 8'h34});
    send({8'h01, 8'h10, 8'h00, 8'h0b, 8'h00, 8'h01, 8'h02, 8'h56, 8'h78}, 0);
    expectResp({8'h01, 8'h10, 8'h00, 8'h0b, 8'h00, 8'h01});
    chkVal(16'(strobes), 16'h0002, "store writes, multi");
    unitNumber = 4'hf;
    send({8'h0f, 8'h17, 8'h00, 8'h40, 8'h00, 8'h01, 8'h00, 8'h0b, 8'h00, 8'h01,
          8'h02, 8'h56, 8'h78}, 0);
    expectResp({8'h0f, 8'h17, 8'h02, 8'h09, 8'h4d});
    printVerdict();
  end
endmodule
